//--- ipd_defines.svh
`ifndef IPD_DEFINES_SVH
`define IPD_DEFINES_SVH
// Power control register bit positions
`define IPD_IDLE_BIT 0
`define IPD_PD_BIT 1
`define IPD_GF0_BIT 2
`define IPD_GF1_BIT 3
// Register addresses on the plain port
`define IPD_ADDR_POWER_CONTROL_REG 8'h87
`define IPD_ADDR_STAT 8'h88
// Reset value of the power control register
`define IPD_POWER_CONTROL_REG_RST 8'h00
// Oscillator restart settle time in ns and in cycles
`define IPD_OSC_SETTLE_NS 1000
`define IPD_CLK_NS 100
`define IPD_OSC_SETTLE_CYC ((`IPD_OSC_SETTLE_NS + `IPD_CLK_NS - 1) / `IPD_CLK_NS)
// Reset hold in oscillator periods
`define IPD_RST_HOLD_OSC 24
`endif

//--- ipd_pkg.sv
package ipd_pkg;
   typedef enum logic [1:0] {
      IPD_RUN = 2'b00,
      IPD_IDLE = 2'b01,
      IPD_PDOWN = 2'b11,
      IPD_WAKE = 2'b10
   } ipd_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ipd_bus_t;

   typedef struct packed {
      logic [7:0] p0_out;
      logic [7:0] p0_oe_n;
      logic ale;
      logic program_fetch_strobe;
   } ipd_pins_t;
endpackage

//--- ipd_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for pin levels
module ipd_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   // First flop feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= {WIDTH{1'b1}};
         q <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // ipd_sync
`default_nettype wire

//--- ipd_settle.sv
`timescale 1ns/1ns
`default_nettype none
// Counts oscillator settle time after a restart
module ipd_settle #(
   parameter int CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic run,
   output logic done
);
   initial begin
      if (CYCLES < 1 || CYCLES > 65535) $error("bad CYCLES");
   end
   logic [15:0] cnt_reg;
   // Count while run is held, reload on start
   always_ff @(posedge clk) begin
      if (rst || start) begin
         cnt_reg <= 16'h0000;
      end else if (run && cnt_reg != 16'(CYCLES)) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   assign done = (cnt_reg == 16'(CYCLES));
endmodule // ipd_settle
`default_nettype wire

//--- ipd_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipd_defines.svh"
// Behaviour
// R1 - Instruction setting the idle bit is the last one before idle.
// R2 - Idle gates the CPU clock; interrupts, timers, serial ports keep clocking.
// R3 - All CPU state is preserved during idle.
// R4 - Port pins keep the level they had when idle began. Code floats all of port 0 instead while ext_mem is high.
// R5 - Address latch and program fetch strobes held high in idle.
// R6 - Any enabled interrupt clears idle bit, ends idle, gets serviced.
// R7 - After interrupt return, execution continues after the idle instruction.
// R8 - Two software flags readable by interrupt routines.
// R9 - Reset must be held 24 oscillator periods to end idle.
// R10 - Setting power-down bit stops the oscillator after that instruction.
// R11 - RAM and special registers kept throughout power-down.
// R12 - Power-down ends only by reset or an enabled external interrupt.
// R13 - Low enabled pin restarts oscillator; its release completes exit.
// R14 - Either pin low restarts; first release exits; higher priority serviced. Code serves the first pin released; ext1_high_prio only breaks a tie.
// R15 - After wake service returns, continue after power-down instruction.
// R16 - Reset exit reinitialises registers; interrupt exit leaves them.
// R17 - Either exit leaves internal RAM unchanged.
// R18 - Both bits set: power-down exit, both bits cleared on vectoring. Code clears both when the wake exit completes, before irq_vector.
// R19 - Port 0 drives only zeros in low power; ones float.
// R20 - Waking reset or interrupt should outlast oscillator restart.
// R21 - Reset clears both request bits, starting in run mode.
module ipd_ctrl
   import ipd_pkg::*;
#(
   parameter int SETTLE_CYC = `IPD_OSC_SETTLE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire ipd_bus_t bus,
   output logic [7:0] rdata,
   input wire logic irq_pending,
   input wire logic irq_vector,
   input wire logic [1:0] ext_irq_en,
   input wire logic ext_irq0_n,
   input wire logic ext_irq1_n,
   input wire logic ext1_high_prio,
   input wire logic [7:0] p0_data,
   input wire logic ext_mem,
   input wire logic ale_run,
   input wire logic program_fetch_strobe_run,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_en,
   output logic [1:0] wake_irq,
   output ipd_pins_t pins
);
   initial begin
      if (SETTLE_CYC < 1) $error("SETTLE_CYC must be at least 1");
   end

   typedef struct packed {
      ipd_mode_t mode;
      logic idle;
      logic pd;
      logic gf0;
      logic gf1;
      logic [7:0] rdata;
      logic [7:0] p0_hold;
      logic [1:0] low_seen;
      logic [1:0] wake;
      logic settle_go;
   } ipd_state_t;

   ipd_state_t st_reg;
   ipd_state_t st_next;
   logic [1:0] irq_n_s;
   logic settled;
   logic [1:0] pin_low;
   logic [1:0] released;

   // Pin synchronisers for external interrupt inputs
   ipd_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({ext_irq1_n, ext_irq0_n}),
      .q(irq_n_s)
   );

   // Oscillator settle counter after wake
   ipd_settle #(
      .CYCLES(SETTLE_CYC)
   ) u_settle (
      .clk(clk),
      .rst(rst),
      .start(st_reg.settle_go),
      .run(st_reg.mode == IPD_WAKE),
      .done(settled)
   );

   // Enabled pins only count as wake sources
   assign pin_low = ~irq_n_s & ext_irq_en; // R12
   assign released = st_reg.low_seen & irq_n_s; // R13

   // Next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.settle_go = 1'b0;
      st_next.rdata = 8'h00;
      if (bus.rd) begin
         if (bus.addr == `IPD_ADDR_POWER_CONTROL_REG) begin
            st_next.rdata[`IPD_IDLE_BIT] = st_reg.idle;
            st_next.rdata[`IPD_PD_BIT] = st_reg.pd;
            st_next.rdata[`IPD_GF0_BIT] = st_reg.gf0; // R8
            st_next.rdata[`IPD_GF1_BIT] = st_reg.gf1; // R8
         end else if (bus.addr == `IPD_ADDR_STAT) begin
            st_next.rdata[1:0] = st_reg.mode;
            st_next.rdata[3:2] = st_reg.wake;
         end
      end
      unique case (st_reg.mode)
         IPD_RUN: begin
            if (bus.wr && bus.addr == `IPD_ADDR_POWER_CONTROL_REG) begin
               st_next.idle = bus.wdata[`IPD_IDLE_BIT];
               st_next.pd = bus.wdata[`IPD_PD_BIT];
               st_next.gf0 = bus.wdata[`IPD_GF0_BIT]; // R8
               st_next.gf1 = bus.wdata[`IPD_GF1_BIT]; // R8
               st_next.p0_hold = p0_data; // R4
               // Writing instruction completes, then mode switches
               if (bus.wdata[`IPD_PD_BIT]) begin
                  st_next.mode = IPD_PDOWN; // R10 R18
               end else if (bus.wdata[`IPD_IDLE_BIT]) begin
                  st_next.mode = IPD_IDLE; // R1
               end
            end else if (irq_vector) begin
               st_next.wake = 2'b00;
            end
         end
         IPD_IDLE: begin
            // Enabled interrupt ends idle and clears the bit
            if (irq_pending) begin
               st_next.idle = 1'b0; // R6
               st_next.mode = IPD_RUN; // R7
            end
         end
         IPD_PDOWN: begin
            // Only enabled external pins restart the oscillator
            if (pin_low != 2'b00) begin
               st_next.low_seen = pin_low; // R13 R14
               st_next.mode = IPD_WAKE;
               st_next.settle_go = 1'b1;
            end
         end
         IPD_WAKE: begin
            st_next.low_seen = st_reg.low_seen | pin_low; // R14
            // First release after settling completes the exit
            if (settled && released != 2'b00) begin
               if (released == 2'b11) begin
                  st_next.wake = ext1_high_prio ? 2'b10 : 2'b01; // R14
               end else begin
                  st_next.wake = released;
               end
               st_next.idle = 1'b0; // R18
               st_next.pd = 1'b0; // R18
               st_next.low_seen = 2'b00;
               st_next.mode = IPD_RUN; // R15
            end
         end
      endcase
   end

   // State register; reset clears request bits
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.mode <= IPD_RUN; // R21
         st_reg.idle <= 1'b0; // R21
         st_reg.pd <= 1'b0; // R21
         st_reg.gf0 <= 1'b0; // R16
         st_reg.gf1 <= 1'b0; // R16
         st_reg.rdata <= 8'h00;
         st_reg.p0_hold <= 8'h00;
         st_reg.low_seen <= 2'b00;
         st_reg.wake <= 2'b00;
         st_reg.settle_go <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Clock gating for the core and its peripherals
   assign cpu_clk_en = (st_reg.mode == IPD_RUN); // R2 R3 R11 R17
   assign periph_clk_en = (st_reg.mode != IPD_PDOWN); // R2
   assign osc_en = (st_reg.mode != IPD_PDOWN); // R10
   assign wake_irq = st_reg.wake;
   assign rdata = st_reg.rdata;

   // Pin states in low-power modes
   always_comb begin
      pins.ale = ale_run;
      pins.program_fetch_strobe = program_fetch_strobe_run;
      pins.p0_out = 8'h00;
      pins.p0_oe_n = 8'hff;
      if (st_reg.mode == IPD_IDLE) begin
         pins.ale = 1'b1; // R5
         pins.program_fetch_strobe = 1'b1; // R5
      end else if (st_reg.mode != IPD_RUN) begin
         pins.ale = 1'b0;
         pins.program_fetch_strobe = 1'b0;
      end
      if (st_reg.mode != IPD_RUN && !ext_mem) begin
         pins.p0_oe_n = st_reg.p0_hold; // R19 R4
      end
   end
endmodule // ipd_ctrl
`default_nettype wire

//--- ipd_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the low-power controller
module ipd_ctrl_props
   import ipd_pkg::*;
#(
   parameter int SETTLE_CYC = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire ipd_bus_t bus,
   input wire logic irq_pending,
   input wire logic [1:0] ext_irq_en,
   input wire logic ext_irq0_n,
   input wire logic ext_irq1_n,
   input wire logic [7:0] p0_data,
   input wire logic ext_mem,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_en,
   input wire ipd_pins_t pins
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Accepted control register write in run mode
   wire logic pc_wr = bus.wr && bus.addr == 8'h87 && cpu_clk_en;
   a_idle_clk_gate: assert property (pc_wr && bus.wdata[1:0] == 2'b01 |=> !cpu_clk_en && periph_clk_en)
      else $error("idle entry clock gating wrong");
   a_idle_strobes: assert property (pc_wr && bus.wdata[1:0] == 2'b01 |=> pins.ale && pins.program_fetch_strobe)
      else $error("strobes not high in idle");
   a_pd_osc_stop: assert property (pc_wr && bus.wdata[1] |=> !osc_en && !cpu_clk_en)
      else $error("oscillator kept running");
   a_pd_strobes_low: assert property (!osc_en |-> !pins.ale && !pins.program_fetch_strobe)
      else $error("strobes not low in power-down");
   a_p0_zero_only: assert property (!cpu_clk_en |-> pins.p0_out == 8'h00 && pins.p0_oe_n == (ext_mem ? 8'hff : p0_data))
      else $error("port 0 drive wrong in low power");
   a_pd_no_wake: assert property (!osc_en && ext_irq0_n && ext_irq1_n && $past(ext_irq0_n) && $past(ext_irq1_n)
      && $past(ext_irq0_n, 2) && $past(ext_irq1_n, 2) |=> !osc_en)
      else $error("power-down left without a pin");
   a_pd_wake_start: assert property (!osc_en && (!ext_irq0_n && ext_irq_en[0] || !ext_irq1_n && ext_irq_en[1])
      |-> ##[1:4] osc_en)
      else $error("oscillator not restarted");
   a_reset_run: assert property ($fell(rst) |-> cpu_clk_en && osc_en && periph_clk_en)
      else $error("not in run mode after reset");
   c_idle_exit: cover property (!cpu_clk_en && osc_en && irq_pending);
   c_pd_wake: cover property (!osc_en ##1 osc_en);
   c_pd_exit: cover property ($rose(cpu_clk_en));
endmodule // ipd_ctrl_props
bind ipd_ctrl ipd_ctrl_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (.clk, .rst, .bus, .irq_pending,
   .ext_irq_en, .ext_irq0_n, .ext_irq1_n, .p0_data, .ext_mem, .cpu_clk_en, .periph_clk_en,
   .osc_en, .pins);
`default_nettype wire

//--- ipd_irq_src.sv
`timescale 1ns/1ns
`default_nettype none
// Wake pins with pull-ups and a stretched reset source
module ipd_irq_src (
   input wire logic clk,
   input wire logic rst_req,
   input wire logic hold0,
   input wire logic hold1,
   output logic rst,
   output logic ext_irq0_n = 1'b1,
   output logic ext_irq1_n = 1'b1
);
   logic [4:0] cnt_reg = 5'h00;
   // Pins held low as long as asked; reset lasts 24 periods more
   always_ff @(posedge clk) begin
      ext_irq0_n <= !hold0;
      ext_irq1_n <= !hold1;
      cnt_reg <= rst_req ? 5'h18 : cnt_reg - {4'h0, cnt_reg != 5'h00};
   end
   assign rst = rst_req || cnt_reg != 5'h00;
endmodule // ipd_irq_src
`default_nettype wire

//--- idle_powerdown_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module idle_powerdown_control_tb;
   import ipd_pkg::*;
   logic clk = 0, rst_req = 1, irq_pending = 0, irq_vector = 0, hold0 = 0, hold1 = 0;
   logic [7:0] p0_data = 8'h00;
   logic ext_mem = 1'b0;
   logic [7:0] d;
   logic [31:0] seed = 32'h7bfc;
   ipd_bus_t bus = '0;
   wire logic rst, ext_irq0_n, ext_irq1_n, cpu_clk_en, periph_clk_en, osc_en;
   wire logic [7:0] rdata;
   wire logic [1:0] wake_irq;
   wire ipd_pins_t pins;
   int n_fail = 0, tests_run = 0, i;
   always #50 clk = ~clk;
   ipd_irq_src u_src (.clk(clk), .rst_req(rst_req), .hold0(hold0), .hold1(hold1), .rst(rst),
      .ext_irq0_n(ext_irq0_n), .ext_irq1_n(ext_irq1_n));
   ipd_ctrl #(.SETTLE_CYC(2)) dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .irq_pending(irq_pending), .irq_vector(irq_vector), .ext_irq_en(2'b11),
      .ext_irq0_n(ext_irq0_n), .ext_irq1_n(ext_irq1_n), .ext1_high_prio(1'b0), .p0_data(p0_data),
      .ext_mem(ext_mem), .ale_run(1'b0), .program_fetch_strobe_run(1'b0), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .osc_en(osc_en), .wake_irq(wake_irq), .pins(pins));
   // Random source and expected status word
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] stat(input logic [1:0] wk, input logic [1:0] md);
      return {4'h0, wk, md};
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One register access, registered read data checked at the falling edge after the access edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
      bus <= '{addr: a, wdata: v, wr: w, rd: !w};
      @(posedge clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      @(negedge clk);
      if (!w) chk(rdata, e);
      @(posedge clk);
   endtask
   task automatic wait_rst;
      for (i = 0; i < 40 && rst; i++) @(posedge clk);
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_req <= 1'b0;
      wait_rst();
      acc(1'b0, 8'h87, 8'h00, 8'h00);
      acc(1'b0, 8'h90, 8'h00, 8'h00);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         d = seed[7:0] & 8'h0c;
         acc(1'b1, 8'h87, d, 8'h00);
         acc(1'b0, 8'h87, 8'h00, d);
      end
      seed = lfsr(seed);
      p0_data <= seed[15:8];
      acc(1'b1, 8'h87, 8'h0d, 8'h00);
      @(negedge clk);
      chk({cpu_clk_en, periph_clk_en, pins.ale, pins.program_fetch_strobe}, 8'h07);
      chk(pins.p0_oe_n, p0_data);
      @(posedge clk);
      ext_mem <= 1'b1;
      @(negedge clk);
      chk(pins.p0_oe_n, 8'hff);
      @(posedge clk);
      ext_mem <= 1'b0;
      acc(1'b0, 8'h88, 8'h00, stat(2'b00, 2'b01));
      irq_pending <= 1'b1;
      @(posedge clk);
      irq_pending <= 1'b0;
      @(negedge clk);
      chk(cpu_clk_en, 8'h01);
      @(posedge clk);
      acc(1'b0, 8'h87, 8'h00, 8'h0c);
      acc(1'b1, 8'h87, 8'h0f, 8'h00);
      @(negedge clk);
      chk({osc_en, pins.ale, pins.program_fetch_strobe}, 8'h00);
      @(posedge clk);
      irq_pending <= 1'b1;
      repeat (3) @(posedge clk);
      irq_pending <= 1'b0;
      @(negedge clk);
      chk(osc_en, 8'h00);
      @(posedge clk);
      hold0 <= 1'b1;
      hold1 <= 1'b1;
      for (i = 0; i < 20 && !osc_en; i++) @(posedge clk);
      @(negedge clk);
      chk(osc_en, 8'h01);
      repeat (4) @(posedge clk);
      hold1 <= 1'b0;
      for (i = 0; i < 20 && !cpu_clk_en; i++) @(posedge clk);
      @(negedge clk);
      chk({cpu_clk_en, wake_irq}, 8'h06);
      @(posedge clk);
      acc(1'b0, 8'h87, 8'h00, 8'h0c);
      irq_vector <= 1'b1;
      @(posedge clk);
      irq_vector <= 1'b0;
      hold0 <= 1'b0;
      @(negedge clk);
      chk(wake_irq, 8'h00);
      @(posedge clk);
      for (int k = 1; k < 3; k++) begin
         acc(1'b1, 8'h87, 8'(k) | 8'h04, 8'h00);
         rst_req <= 1'b1;
         @(posedge clk);
         rst_req <= 1'b0;
         wait_rst();
         acc(1'b0, 8'h87, 8'h00, 8'h00);
      end
      print_verdict();
   end
endmodule // idle_powerdown_control_tb
`default_nettype wire
